// File: rtl/rcd_top.sv
// ten-meg rate code decode and test register bank
// assumes a single-cycle management register port on the core clock
//
// Overview of operation
// - one code table for all eight fields
// - codes 1 to 9 give whole megabits
// - codes 0 and 10 mean full rate
// - codes 101 to 115 give 64k steps
// - phase bit inverts transmit clock input sense
// - mii-only variant keeps phase bit read-only zero
// - test register b is writable, resets 0x0C
`timescale 1ns/100ps
module rcd_top
	import rcd_pkg::*;
#(
	parameter bit MII_ONLY = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// management register port
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// rate limit codes: ingress prio 0-3, then egress prio 0-3
	input wire logic tenMegMode,
	input wire logic [7:0][6:0] limitCode,
	output logic [7:0][13:0] limitKbps,
	output logic [7:0] limitActive,
	output logic decodeValid,
	// cpu port clocking and test outputs
	output logic cpuTxClkInvert,
	output logic [7:0] testRegB
);

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic phaseInv_q;
	logic [7:0] testRegB_q;
	logic [7:0] rdData_q;
	logic rdValid_q;
	logic tenMeg_q;

	function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic [7:0] readValue(input logic [7:0] a, input logic inv,
		input logic [7:0] b);
		logic [7:0] v;
		v = UNMAPPED_RD;
		if (hitAddr(a, TEST_REG_A_OFS)) begin
			v = TEST_REG_A_RST;
		end else if (hitAddr(a, RESERVED_CONTROL_REG_OFS)) begin
			v = RESERVED_CONTROL_REG_RST;
		end else if (hitAddr(a, TEST_REG_B_OFS)) begin
			v = b;
		end else if (hitAddr(a, TEST_REG_C_OFS)) begin
			v = TEST_REG_C_RST;
		end else if (hitAddr(a, TEST_REG_CLOCK_PHASE_OFS)) begin
			v = 8'h00;
			v[PHASE_INV_BIT] = inv;
		end
		return v;
	endfunction

	// ----------------------------------------
	// clock phase control
	// ----------------------------------------
	// on back to back links software sets this on the normal-mode end only
	always_ff @(posedge mclk) begin
		if (rst) begin
			phaseInv_q <= 1'b0;
		end else if (regWrEn && hitAddr(regAddr, TEST_REG_CLOCK_PHASE_OFS) && !MII_ONLY) begin
			phaseInv_q <= regWrData[PHASE_INV_BIT];
		end
	end

	// ----------------------------------------
	// test register b
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			testRegB_q <= TEST_REG_B_RST;
		end else if (regWrEn && hitAddr(regAddr, TEST_REG_B_OFS)) begin
			testRegB_q <= regWrData;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// read-only registers are constants; writes to them simply fall away
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_q <= UNMAPPED_RD;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= regRdEn;
			if (regRdEn) begin
				rdData_q <= readValue(regAddr, phaseInv_q, testRegB_q);
			end
		end
	end

	// ----------------------------------------
	// rate decode
	// ----------------------------------------
	rcd_rate_if rateIf ();

	genvar k;
	generate
		for (k = 0; k < NUM_CODES; k++) begin : g_link
			assign rateIf.code[k] = limitCode[k];
			assign limitKbps[k] = rateIf.rateKbps[k];
			assign limitActive[k] = rateIf.limited[k] & tenMeg_q;
		end
	endgenerate

	rcd_rate_decode u_decode (
		.mclk(mclk),
		.rst(rst),
		.rateIf(rateIf)
	);

	// rates only hold for a port in ten-meg mode; the other table lives elsewhere
	always_ff @(posedge mclk) begin
		if (rst) begin
			tenMeg_q <= 1'b0;
		end else begin
			tenMeg_q <= tenMegMode;
		end
	end

	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign decodeValid = tenMeg_q;
	assign cpuTxClkInvert = phaseInv_q;
	assign testRegB = testRegB_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	generate
		for (k = 0; k < NUM_CODES; k++) begin : g_chk
			a_same_table: assert property (@(posedge mclk) disable iff (rst)
				limitCode[k] == limitCode[0] |=> limitKbps[k] == limitKbps[0])
				else $error("fields decode differently");
			a_whole_mbps: assert property (@(posedge mclk) disable iff (rst)
				(limitCode[k] >= 7'h01 && limitCode[k] <= 7'h09)
				|=> limitKbps[k] == 14'(14'($past(limitCode[k])) * 14'h03E8))
				else $error("megabit code decoded wrong");
			a_full_rate: assert property (@(posedge mclk) disable iff (rst)
				(limitCode[k] == 7'h00 || limitCode[k] == 7'h0A)
				|=> limitKbps[k] == 14'h2710 && !limitActive[k])
				else $error("full rate code limited");
			a_sub_mbps: assert property (@(posedge mclk) disable iff (rst)
				(limitCode[k] >= 7'h65 && limitCode[k] <= 7'h73) ##1 tenMeg_q
				|-> limitKbps[k] == 14'(14'($past(limitCode[k]) - 7'h64) * 14'h0040)
				&& limitActive[k])
				else $error("sub megabit code decoded wrong");
			a_undefined_code: assert property (@(posedge mclk) disable iff (rst)
				((limitCode[k] > 7'h0A && limitCode[k] < 7'h65) || limitCode[k] > 7'h73)
				|=> limitKbps[k] == 14'h2710)
				else $error("undefined code limits traffic");
		end
	endgenerate

	a_reset_full: assert property (@(posedge mclk)
		rst |=> limitKbps[0] == 14'h2710 && limitKbps[7] == 14'h2710)
		else $error("rate not full after reset");

	a_phase_write: assert property (@(posedge mclk) disable iff (rst)
		regWrEn && regAddr == 8'hFF && !MII_ONLY
		|=> cpuTxClkInvert == $past(regWrData[6]))
		else $error("phase bit write lost");

	a_phase_reset: assert property (@(posedge mclk)
		rst |=> !cpuTxClkInvert)
		else $error("phase bit set after reset");

	a_phase_readback: assert property (@(posedge mclk) disable iff (rst)
		regRdEn && regAddr == 8'hFF && !regWrEn ##1 1'b1
		|-> regRdValid && regRdData == {1'b0, cpuTxClkInvert && !MII_ONLY, 6'h00})
		else $error("phase register reads wrong");

	a_mii_readonly: assert property (@(posedge mclk) disable iff (rst)
		MII_ONLY |-> !cpuTxClkInvert)
		else $error("phase bit moved in mii-only variant");

	a_testb_write: assert property (@(posedge mclk) disable iff (rst)
		regWrEn && regAddr == 8'hDF ##1 regRdEn && regAddr == 8'hDF && !regWrEn
		|=> regRdData == $past(regWrData, 2))
		else $error("test register b readback wrong");

	a_testb_reset: assert property (@(posedge mclk)
		rst |=> testRegB == 8'h0C)
		else $error("test register b reset wrong");

endmodule

// File: shared/rcd_pkg.sv
// rate code decode package: register map, reset values, code table limits
// assumes an 8-bit management register space and a 125 MHz core clock
package rcd_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] TEST_REG_A_OFS = 8'hBF;
	localparam logic [7:0] RESERVED_CONTROL_REG_OFS = 8'hCF;
	localparam logic [7:0] TEST_REG_B_OFS = 8'hDF;
	localparam logic [7:0] TEST_REG_C_OFS = 8'hEF;
	localparam logic [7:0] TEST_REG_CLOCK_PHASE_OFS = 8'hFF;

	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [7:0] TEST_REG_A_RST = 8'h80;
	localparam logic [7:0] RESERVED_CONTROL_REG_RST = 8'h15;
	localparam logic [7:0] TEST_REG_B_RST = 8'h0C;
	localparam logic [7:0] TEST_REG_C_RST = 8'h32;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam int PHASE_INV_BIT = 6;

	// ----------------------------------------
	// rate codes, in kbit/s
	// ----------------------------------------
	localparam int NUM_CODES = 8;
	localparam int CODE_W = 7;
	localparam int RATE_W = 14;
	localparam logic [6:0] CODE_FULL = 7'h00;
	localparam logic [6:0] CODE_MBPS_LO = 7'h01;
	localparam logic [6:0] CODE_MBPS_HI = 7'h09;
	localparam logic [6:0] CODE_FULL_ALT = 7'h0A;
	localparam logic [6:0] CODE_SUB_BASE = 7'h64;
	localparam logic [6:0] CODE_SUB_LO = 7'h65;
	localparam logic [6:0] CODE_SUB_HI = 7'h73;
	localparam logic [13:0] MBPS_KBPS = 14'h03E8;
	localparam logic [13:0] STEP_KBPS = 14'h0040;
	localparam logic [13:0] FULL_KBPS = 14'h2710;

endpackage

// File: shared/rcd_rate_if.sv
// rate code carrier between the register top and the code decoder
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface rcd_rate_if;
	logic [6:0] code [8];
	logic [13:0] rateKbps [8];
	logic limited [8];

	modport decoder (input code, output rateKbps, output limited);
	modport user (output code, input rateKbps, input limited);
endinterface

// File: rtl/rcd_rate_decode.sv
// registered decoder of 7-bit ten-meg rate codes into kbit/s
// assumes codes are stable enough to be sampled once per clock
`timescale 1ns/100ps
module rcd_rate_decode
	import rcd_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// codes in, rates out
	rcd_rate_if.decoder rateIf
);

	// ----------------------------------------
	// one code to a rate
	// ----------------------------------------
	function automatic logic [13:0] codeToKbps(input logic [6:0] c);
		logic [13:0] r;
		// zero, ten and every unlisted code fall through to full rate
		r = FULL_KBPS;
		if (c >= CODE_MBPS_LO && c <= CODE_MBPS_HI) begin
			r = 14'(14'(c) * MBPS_KBPS);
		end else if (c >= CODE_SUB_LO && c <= CODE_SUB_HI) begin
			r = 14'(14'(c - CODE_SUB_BASE) * STEP_KBPS);
		end
		return r;
	endfunction

	// ----------------------------------------
	// same table for every field
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_CODES; i++) begin : g_code
			logic [13:0] rate_q;
			always_ff @(posedge mclk) begin
				if (rst) begin
					rate_q <= FULL_KBPS;
				end else begin
					rate_q <= codeToKbps(rateIf.code[i]);
				end
			end
			assign rateIf.rateKbps[i] = rate_q;
			assign rateIf.limited[i] = (rate_q != FULL_KBPS);
		end
	endgenerate

endmodule

// File: tb/rcd_host_model.sv
// management processor model: drives the register port of the block
// assumes the block samples strobes on the rising core clock edge
`timescale 1ns/100ps
module rcd_host_model
	import rcd_pkg::*;
(
	// clock
	input wire logic mclk,
	// register port requests
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	output logic regRdEn
);
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	// ----------------------------------------
	// one request per cycle, back to back allowed
	// ----------------------------------------
	// phase bit is only set by software on the normal-side device
	task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		regAddr = a;
		regWrEn = wr;
		regWrData = d;
		regRdEn = rd;
	endtask
endmodule

// File: tb/tb.sv
// self-checking bench for the rate code decoder and test registers
// assumes host model drives the register port; a second top checks mii-only
`timescale 1ns/100ps
module tb
	import rcd_pkg::*;
;
	logic mclk, rst, regWrEn, regRdEn, tenMegMode, regRdValid, decodeValid, cpuTxClkInvert;
	logic regRdValidM, cpuTxClkInvertM;
	logic [7:0] regAddr, regWrData, regRdData, regRdDataM, testRegB, limitActive;
	logic [7:0][6:0] limitCode;
	logic [7:0][13:0] limitKbps;
	logic [7:0] rdExpQ[$];
	int error_cnt = 0, tests_run = 0, seed = 63410;
	logic [7:0] d;

	rcd_host_model u_rcd_host_model (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn));
	rcd_top u_rcd_top (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .tenMegMode(tenMegMode), .limitCode(limitCode),
		.limitKbps(limitKbps), .limitActive(limitActive), .decodeValid(decodeValid),
		.cpuTxClkInvert(cpuTxClkInvert), .testRegB(testRegB));
	// second variant shares the register port; its phase bit, read valid and phase register readback are checked
	rcd_top #(.MII_ONLY(1'b1)) u_rcd_top_mii (.mclk(mclk), .rst(rst), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdDataM), .regRdValid(regRdValidM), .tenMegMode(tenMegMode),
		.limitCode(limitCode), .limitKbps(), .limitActive(), .decodeValid(),
		.cpuTxClkInvert(cpuTxClkInvertM), .testRegB());

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [13:0] kbps(input int c);
		if (c >= 1 && c <= 9)
			return 14'(c * MBPS_KBPS);
		if (c >= 101 && c <= 115)
			return 14'((c - 100) * STEP_KBPS);
		return FULL_KBPS;
	endfunction

	// ----------------------------------------
	// read answers: oldest note against each valid pulse
	// ----------------------------------------
	always @(negedge mclk) begin
		if (regRdValid === 1'b1) begin
			chk(regRdValidM, 1'b1);
			if (rdExpQ.size() == 0)
				chk(32'h1, 32'h0);
			else
				chk(regRdData, rdExpQ.pop_front());
		end
	end

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdExpQ.push_back(e);
		u_rcd_host_model.op(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic idle(input int n);
		repeat (n) u_rcd_host_model.op(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		tenMegMode = 1'b0;
		limitCode = '0;
		repeat (6) @(posedge mclk);
		#1;
		rst = 1'b0;
		@(negedge mclk);
		for (int i = 0; i < 8; i++)
			chk(limitKbps[i], FULL_KBPS);
		chk(testRegB, TEST_REG_B_RST);
		chk(cpuTxClkInvert, 1'b0);
		// reset values of the whole map, then an unmapped place
		rd(TEST_REG_A_OFS, TEST_REG_A_RST);
		rd(RESERVED_CONTROL_REG_OFS, RESERVED_CONTROL_REG_RST);
		rd(TEST_REG_B_OFS, TEST_REG_B_RST);
		rd(TEST_REG_C_OFS, TEST_REG_C_RST);
		rd(TEST_REG_CLOCK_PHASE_OFS, 8'h00);
		rd(8'h10, UNMAPPED_RD);
		$display("test reset values done");
		// writes to read-only places, then a read-write pair in one cycle
		d = 8'($random(seed));
		u_rcd_host_model.op(1'b1, 1'b0, TEST_REG_A_OFS, 8'h5A);
		u_rcd_host_model.op(1'b1, 1'b0, TEST_REG_C_OFS, 8'hA5);
		rdExpQ.push_back(TEST_REG_B_RST);
		u_rcd_host_model.op(1'b1, 1'b1, TEST_REG_B_OFS, d);
		rd(TEST_REG_B_OFS, d);
		rd(TEST_REG_A_OFS, TEST_REG_A_RST);
		rd(TEST_REG_C_OFS, TEST_REG_C_RST);
		idle(1);
		chk(testRegB, d);
		// phase bit: only bit 6 stored; mii-only variant ignores it
		u_rcd_host_model.op(1'b1, 1'b0, TEST_REG_CLOCK_PHASE_OFS, 8'hFF);
		rd(TEST_REG_CLOCK_PHASE_OFS, 8'h40);
		idle(2);
		chk(cpuTxClkInvert, 1'b1);
		chk(cpuTxClkInvertM, 1'b0);
		chk(regRdDataM, 8'h00);
		u_rcd_host_model.op(1'b1, 1'b0, TEST_REG_CLOCK_PHASE_OFS, 8'hBF);
		idle(2);
		chk(cpuTxClkInvert, 1'b0);
		$display("test registers done");
		// every code in lane 0, random codes elsewhere, random mode
		for (int c = 0; c < 128; c++) begin
			@(posedge mclk);
			#1;
			tenMegMode = 1'($random(seed));
			limitCode[0] = 7'(c);
			for (int i = 1; i < 8; i++)
				limitCode[i] = 7'($random(seed));
			@(posedge mclk);
			@(negedge mclk);
			chk(decodeValid, tenMegMode);
			for (int i = 0; i < 8; i++) begin
				chk(limitKbps[i], kbps(limitCode[i]));
				chk(limitActive[i], tenMegMode && kbps(limitCode[i]) != FULL_KBPS);
			end
		end
		$display("test rate decode done");
		idle(2);
		chk(rdExpQ.size(), 0);
		end_of_test();
	end
endmodule
